// ==== rtl/rpmc_cfg.svh ====
// constants for the radio power-mode control block
// assumes a 200 MHz ref_clk and a single AHB-Lite slave port
`ifndef RPMC_CFG_SVH
`define RPMC_CFG_SVH
`define RPMC_OFS_MODE   12'h000
`define RPMC_OFS_STAT   12'h004
`define RPMC_OFS_IRQST  12'h008
`define RPMC_OFS_IRQCLR 12'h00C
`define RPMC_OFS_IRQEN  12'h010
`define RPMC_MODE_RETOFF 4'h0
`define RPMC_MODE_TOTOFF 4'h1
`define RPMC_MODE_XTAL   4'h5
`define RPMC_MODE_BUF    4'h6
`define RPMC_MODE_RXSYN  4'h8
`define RPMC_MODE_RXACT  4'h9
`define RPMC_MODE_WOR    4'hB
`define RPMC_MODE_TXSYN  4'hC
`define RPMC_MODE_TXACT  4'hD
`define RPMC_REG_SETTLE_NS 2000
`define RPMC_INIT_NS       10000
`define RPMC_CLK_NS        5
`endif

// ==== rtl/rpmc_decode.sv ====
// decodes the power-mode field into supply and function enables
// assumes the field is held stable by the caller
`timescale 1ns/1ps
`default_nettype none
`include "rpmc_cfg.svh"
module rpmc_decode (
  // mode in
  input  wire logic [3:0]          mode,
  // enables out
  output rpmc_pkg::rpmc_supply_t   sup
);
  import rpmc_pkg::*;
  always_comb begin
    sup = '0;
    case (mode)
      `RPMC_MODE_XTAL: begin
        sup.core_on = 1'b1;
        sup.ref_on  = 1'b1;
      end
      `RPMC_MODE_BUF: begin
        sup.core_on = 1'b1;
        sup.ref_on  = 1'b1;
        sup.buf_ok  = 1'b1;
      end
      `RPMC_MODE_RXSYN, `RPMC_MODE_TXSYN: begin
        sup.core_on  = 1'b1;
        sup.ref_on   = 1'b1;
        sup.synth_on = 1'b1;
        sup.buf_ok   = 1'b1;
      end
      `RPMC_MODE_RXACT: begin
        sup.core_on  = 1'b1;
        sup.ref_on   = 1'b1;
        sup.synth_on = 1'b1;
        sup.rx_on    = 1'b1;
        sup.buf_ok   = 1'b1;
      end
      `RPMC_MODE_TXACT: begin
        sup.core_on  = 1'b1;
        sup.ref_on   = 1'b1;
        sup.synth_on = 1'b1;
        sup.tx_on    = 1'b1;
        sup.buf_ok   = 1'b1;
      end
      `RPMC_MODE_WOR: sup.lpo_on = 1'b1;
      default: sup = '0; // retention-off, total-off and unknown codes
    endcase
  end
endmodule
`default_nettype wire

// ==== rtl/rpmc_pkg.sv ====
// types for the radio power-mode control block
// assumes nothing beyond the constants header
package rpmc_pkg;
  typedef enum logic [3:0] {
    RPMC_ST_OFF    = 4'b0001,
    RPMC_ST_RAMP   = 4'b0010,
    RPMC_ST_READY  = 4'b0100,
    RPMC_ST_INIT   = 4'b1000
  } rpmc_state_t;
  typedef struct packed {
    logic core_on;
    logic ref_on;
    logic synth_on;
    logic rx_on;
    logic tx_on;
    logic lpo_on;
    logic buf_ok;
  } rpmc_supply_t;
  typedef struct packed {
    logic brownout;
    logic regulator_ready;
  } rpmc_flags_t;
endpackage

// ==== rtl/rpmc_top.sv ====
// radio power-mode control: register slave, regulator sequencer, flags
// assumes AHB-Lite single word transfers and synchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
`include "rpmc_cfg.svh"
module rpmc_top #(
  parameter int SETTLE_NS = `RPMC_REG_SETTLE_NS,
  parameter int INIT_NS   = `RPMC_INIT_NS
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [11:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // analog status
  input  wire logic                 supply_low,
  // buffer status and control
  input  wire logic                 buf_empty,
  output logic                      buf_flush,
  // wake pins
  input  wire logic                 sel_n,
  output logic                      miso_o,
  output logic                      miso_oe,
  // supply and function enables, interrupt
  output rpmc_pkg::rpmc_supply_t    supply,
  output logic                      irq
);
  import rpmc_pkg::*;
  localparam int SETTLE_CYC = (SETTLE_NS + `RPMC_CLK_NS - 1) / `RPMC_CLK_NS;
  localparam int INIT_CYC   = (INIT_NS + `RPMC_CLK_NS - 1) / `RPMC_CLK_NS;
  localparam int CW = $clog2(SETTLE_CYC > INIT_CYC ? SETTLE_CYC : INIT_CYC)+1;

  // refused at elaboration: a zero count would wrap to the counter maximum in ramp or init
  if (SETTLE_CYC < 1 || INIT_CYC < 1) begin : g_bad_counts
    $error("rpmc_top: settle and init counts must be positive");
  end

  logic [3:0]        mode_r;
  logic [3:0]        applied_r;
  rpmc_state_t       state_r;
  logic [CW-1:0]     cnt_r;
  logic              ready_r;
  logic [1:0]        ist_r;
  logic [1:0]        ien_r;
  logic              bo_q_r;
  logic              rdy_q_r;
  logic              ap_wr_r;
  logic              ap_rd_r;
  logic [11:0]       ap_addr_r;
  rpmc_supply_t      dec;
  rpmc_flags_t       flags;
  logic              ap_go;
  logic              mode_wr;
  logic              init_done;

  assign ap_go = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ap_wr_r   <= 1'b0;
      ap_rd_r   <= 1'b0;
      ap_addr_r <= 12'h000;
    end else begin
      ap_wr_r   <= ap_go && hwrite;
      ap_rd_r   <= ap_go && !hwrite;
      ap_addr_r <= haddr;
    end
  end

  // writes to the mode field are ignored while total-off wake is pending
  assign mode_wr = ap_wr_r && (ap_addr_r == `RPMC_OFS_MODE)
                   && (state_r != RPMC_ST_OFF || mode_r != `RPMC_MODE_TOTOFF);
  assign init_done = (state_r == RPMC_ST_INIT) && (cnt_r == '0);

  // mode register: lost in total-off, kept in retention-off
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r <= `RPMC_MODE_RETOFF;
    end else if (init_done) begin
      mode_r <= `RPMC_MODE_RETOFF;
    end else if (mode_wr) begin
      mode_r <= hwdata[3:0];
    end
  end

  // applied mode follows the field, but retention-off and xtal entry wait for buf_empty
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      applied_r <= `RPMC_MODE_RETOFF;
    end else if (init_done) begin
      applied_r <= `RPMC_MODE_RETOFF;
    end else if (mode_r == `RPMC_MODE_RETOFF
                 || mode_r == `RPMC_MODE_XTAL) begin
      if (buf_empty || applied_r == mode_r)
        applied_r <= mode_r;
    end else begin
      applied_r <= mode_r;
    end
  end

  rpmc_decode u_dec (
    .mode (applied_r),
    .sup  (dec)
  );

  // regulator sequencer: ramp when core supply is needed while the sequencer is off
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= RPMC_ST_OFF;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        RPMC_ST_OFF: begin
          if (applied_r == `RPMC_MODE_TOTOFF && !sel_n) begin
            state_r <= RPMC_ST_INIT;
            cnt_r   <= CW'(INIT_CYC - 1);
          end else if (dec.core_on) begin
            state_r <= RPMC_ST_RAMP;
            cnt_r   <= CW'(SETTLE_CYC - 1);
          end
        end
        RPMC_ST_RAMP: begin
          if (!dec.core_on) begin
            state_r <= RPMC_ST_OFF;
          end else if (cnt_r == '0) begin
            state_r <= RPMC_ST_READY;
          end else begin
            cnt_r <= cnt_r - CW'(1);
          end
        end
        RPMC_ST_READY: begin
          if (!dec.core_on) state_r <= RPMC_ST_OFF;
        end
        RPMC_ST_INIT: begin
          if (cnt_r == '0) state_r <= RPMC_ST_OFF;
          else cnt_r <= cnt_r - CW'(1);
        end
        default: state_r <= RPMC_ST_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) ready_r <= 1'b0;
    else ready_r <= (state_r == RPMC_ST_READY) && dec.core_on;
  end

  // analog functions except core, ref and low-power osc stay off until regulators report ready
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      supply <= '0;
    end else begin
      supply          <= dec;
      supply.synth_on <= dec.synth_on && ready_r;
      supply.rx_on    <= dec.rx_on && ready_r;
      supply.tx_on    <= dec.tx_on && ready_r;
      supply.buf_ok   <= dec.buf_ok && ready_r;
    end
  end

  // buffer contents are dropped whenever the applied mode withdraws access, not while only ready_r holds access off
  always_ff @(posedge ref_clk) begin
    if (rst) buf_flush <= 1'b0;
    else buf_flush <= !dec.buf_ok;
  end

  // miso held low in total-off and during wake initialisation, released otherwise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      miso_o  <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      // low from total-off entry through init, so no stray high is seen
      // before the wake rising edge
      miso_o  <= (state_r != RPMC_ST_INIT)
                 && (applied_r != `RPMC_MODE_TOTOFF);
      miso_oe <= !sel_n;
    end
  end

  assign flags.regulator_ready = ready_r;
  assign flags.brownout        = supply_low;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bo_q_r  <= 1'b0;
      rdy_q_r <= 1'b0;
    end else begin
      bo_q_r  <= flags.brownout;
      rdy_q_r <= flags.regulator_ready;
    end
  end

  // events: bit0 regulators became ready, bit1 brown-out asserted
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ist_r <= 2'h0;
    end else if (init_done) begin
      ist_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0 && flags.regulator_ready && !rdy_q_r)
            || (i == 1 && flags.brownout && !bo_q_r))
          ist_r[i] <= 1'b1; // set wins over clear
        else if (ap_wr_r && ap_addr_r == `RPMC_OFS_IRQCLR && hwdata[i])
          ist_r[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) ien_r <= 2'h0;
    else if (init_done) ien_r <= 2'h0;
    else if (ap_wr_r && ap_addr_r == `RPMC_OFS_IRQEN) ien_r <= hwdata[1:0];
  end

  assign irq = |(ist_r & ien_r);

  // read data registered at the address phase, valid in the data phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_go && !hwrite) begin
      if (haddr == `RPMC_OFS_MODE)
        hrdata <= {28'h0000000, mode_r};
      else if (haddr == `RPMC_OFS_STAT)
        hrdata <= {30'h0, flags};
      else if (haddr == `RPMC_OFS_IRQST)
        hrdata <= {30'h0, ist_r};
      else if (haddr == `RPMC_OFS_IRQEN)
        hrdata <= {30'h0, ien_r};
      else
        hrdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ==== tb/rpmc_host.sv ====
// host controller model: ahb-lite master and radio sessions
// assumes one zero-or-more wait slave on the bus
`timescale 1ns/1ps
`default_nettype none
`include "rpmc_cfg.svh"
module rpmc_host #(
  parameter int SETTLE = 8
) (
  // clock
  input wire logic         ref_clk,
  // ahb-lite master
  output logic             hsel,
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input wire logic         hready,
  input wire logic [31:0]  hrdata
);
  int stuck = 0;
  initial begin
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task automatic hold(inout int n);
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
  endtask
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hold(n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hold(n);
    q = hrdata;
    // released data lines must not look like the last word
    hwdata <= ~d;
    if (n >= 64)
      stuck++;
  endtask
  // settle time is scaled down; the crystal wait is a host duty
  task automatic session(input logic [3:0] act, output logic [31:0] st);
    logic [31:0] q;
    int          n;
    xfer(1'b1, `RPMC_OFS_MODE, 32'h0, q);
    xfer(1'b1, `RPMC_OFS_MODE, {28'h0, `RPMC_MODE_XTAL}, q);
    repeat (SETTLE) @(posedge ref_clk);
    n = 0;
    st = 32'h0;
    while (st[0] !== 1'b1 && n < 100) begin
      xfer(1'b0, `RPMC_OFS_STAT, 32'h0, st);
      n++;
    end
    if (n == 100)
      stuck++;
    xfer(1'b1, `RPMC_OFS_MODE, {28'h0, act}, q);
  endtask
endmodule
`default_nettype wire

// ==== tb/rpmc_properties.sv ====
// port checker for the radio power-mode control block
// assumes it is bound onto rpmc_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rpmc_properties
  import rpmc_pkg::*;
#(
  parameter int SETTLE_NS = 20,
  parameter int INIT_NS   = 50
) (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst,
  // pins
  input wire logic                   buf_empty,
  input wire logic                   buf_flush,
  input wire logic                   sel_n,
  input wire logic                   miso_o,
  input wire logic                   miso_oe,
  input wire rpmc_pkg::rpmc_supply_t supply
);
  // margin covers the registered miso outputs and the init counter
  localparam int WAKE_MAX = INIT_NS / 5 + 4;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_wake_start;
    $rose(miso_oe) ##0 !miso_o;
  endsequence
  sequence s_wake_done;
    ##[1:WAKE_MAX] miso_o;
  endsequence
  a_tx_powered: assert property (
    supply.tx_on |-> supply.core_on && supply.synth_on)
    else $error("transmit on without core and synth");
  a_rx_powered: assert property (
    supply.rx_on |-> supply.core_on && supply.synth_on)
    else $error("receive on without core and synth");
  a_rx_tx_excl: assert property (
    !(supply.rx_on && supply.tx_on))
    else $error("receive and transmit both on");
  a_flush_blocks: assert property (
    buf_flush |-> !supply.buf_ok)
    else $error("buffer open while flushed");
  a_flush_idle: assert property (
    buf_flush |-> !supply.rx_on && !supply.tx_on)
    else $error("radio active while buffer withdrawn");
  a_drain_wait: assert property (
    supply.core_on && !buf_empty |=> supply.core_on)
    else $error("core dropped before buffer drained");
  a_sel_drives: assert property (
    !sel_n |=> miso_oe)
    else $error("miso not driven after select");
  a_wake_done: assert property (
    s_wake_start |-> s_wake_done)
    else $error("wake init did not finish in time");
endmodule
bind rpmc_top rpmc_properties #(
  .SETTLE_NS(SETTLE_NS),
  .INIT_NS  (INIT_NS)
) u_props (
  .ref_clk  (ref_clk),
  .rst      (rst),
  .buf_empty(buf_empty),
  .buf_flush(buf_flush),
  .sel_n    (sel_n),
  .miso_o   (miso_o),
  .miso_oe  (miso_oe),
  .supply   (supply)
);
`default_nettype wire

// ==== tb/tb_radio_power_mode_control.sv ====
// bench for the radio power-mode control block
// assumes the host model drives the bus, this module the pins
`timescale 1ns/1ps
`default_nettype none
`include "rpmc_cfg.svh"
module tb_radio_power_mode_control;
  import rpmc_pkg::*;
  logic         ref_clk = 1'b0;
  logic         rst, hsel, hwrite, hreadyout, hresp, irq;
  logic         supply_low, buf_empty, buf_flush;
  logic         sel_n, miso_o, miso_oe;
  logic [11:0]  haddr;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  hwdata, hrdata, st;
  rpmc_supply_t supply;
  int           err_count = 0;
  int           checked = 0;
  int           i;
  logic [3:0]   codes [8] = '{`RPMC_MODE_XTAL, `RPMC_MODE_BUF,
    `RPMC_MODE_RXSYN, `RPMC_MODE_RXACT, `RPMC_MODE_TXSYN,
    `RPMC_MODE_TXACT, `RPMC_MODE_WOR, `RPMC_MODE_RETOFF};
  // masked to core, synth, rx, tx, low-power osc
  logic [6:0]   exps [8] = '{7'h40, 7'h40, 7'h50, 7'h58,
    7'h50, 7'h54, 7'h02, 7'h00};
  always #2.5 ref_clk = ~ref_clk;
  rpmc_top #(.SETTLE_NS(20), .INIT_NS(50)) dut (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .supply_low(supply_low),
    .buf_empty(buf_empty), .buf_flush(buf_flush), .sel_n(sel_n),
    .miso_o(miso_o), .miso_oe(miso_oe), .supply(supply), .irq(irq));
  rpmc_host u_host (
    .ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_host.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_host.xfer(1'b1, a, d, q);
  endtask
  task automatic wait_sup(input logic [6:0] exp);
    int n;
    n = 0;
    while ((supply & 7'h5E) !== exp && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    chk({25'h0, supply & 7'h5E}, {25'h0, exp});
  endtask
  task automatic summarize();
    err_count += u_host.stuck;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    supply_low = 1'b0;
    buf_empty = 1'b1;
    sel_n = 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`RPMC_OFS_MODE, 32'h0);
    rd(`RPMC_OFS_STAT, 32'h0);
    rd(12'h0F0, 32'h0);
    wait_sup(7'h00);
    $display("reset state done");
    u_host.session(`RPMC_MODE_RXACT, st);
    chk(st, 32'h1);
    wait_sup(7'h58);
    u_host.session(`RPMC_MODE_TXACT, st);
    wait_sup(7'h54);
    $display("sessions done");
    for (i = 0; i < 8; i++) begin
      wr(`RPMC_OFS_MODE, {28'h0, codes[i]});
      rd(`RPMC_OFS_MODE, {28'h0, codes[i]});
      wait_sup(exps[i]);
    end
    $display("mode table done");
    wr(`RPMC_OFS_MODE, {28'h0, `RPMC_MODE_RXACT});
    wait_sup(7'h58);
    chk({31'h0, supply.buf_ok}, 32'h1);
    chk({31'h0, supply.ref_on}, 32'h1);
    @(posedge ref_clk);
    buf_empty <= 1'b0;
    wr(`RPMC_OFS_MODE, 32'h0);
    repeat (20) @(negedge ref_clk);
    chk({31'h0, supply.core_on}, 32'h1);
    @(posedge ref_clk);
    buf_empty <= 1'b1;
    wait_sup(7'h00);
    chk({31'h0, buf_flush}, 32'h1);
    $display("drain done");
    @(posedge ref_clk);
    supply_low <= 1'b1;
    rd(`RPMC_OFS_STAT, 32'h2);
    rd(`RPMC_OFS_IRQST, 32'h3);
    wr(`RPMC_OFS_IRQEN, 32'h2);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    wr(`RPMC_OFS_IRQCLR, 32'h3);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    rd(`RPMC_OFS_IRQST, 32'h0);
    $display("brown-out done");
    @(posedge ref_clk);
    supply_low <= 1'b0;
    wr(`RPMC_OFS_MODE, {28'h0, `RPMC_MODE_TOTOFF});
    wait_sup(7'h00);
    @(posedge ref_clk);
    sel_n <= 1'b0;
    for (i = 0; i < 100 && miso_oe !== 1'b1; i++)
      @(negedge ref_clk);
    chk({31'h0, miso_o}, 32'h0);
    for (i = 0; i < 100 && miso_o !== 1'b1; i++)
      @(negedge ref_clk);
    chk({31'h0, miso_o}, 32'h1);
    @(posedge ref_clk);
    sel_n <= 1'b1;
    rd(`RPMC_OFS_MODE, 32'h0);
    rd(`RPMC_OFS_IRQEN, 32'h0);
    $display("total-off done");
    summarize();
  end
endmodule
`default_nettype wire
